// File: src/dsi_pkg.sv
// Overview of operation
// - Commands latched on command clock rising edge
// - Address carries location, or mode value
// - Bank select routes command to bank
// - Chip select low enables command decoder
// - Deselected: new commands ignored, operations continue
// - Command decoded from write, refresh, select
// - Write data sampled on both clock edges
// - Masked beats are not stored
// - Mask sampled on both write clock edges
// - Column field shrinks as burst grows
// - Burst times column span equals eight
// - Burst length two, four or eight
// - Read data follows both read clock edges
// - Valid flag marks read data exactly
package dsi_pkg;
    localparam int MCLK_PERIOD_NS   = 100;
    localparam int RD_CLK_PERIOD_NS = 800;
    // Half period of the generated read clock in mclk cycles
    localparam int RD_HALF_INT      = RD_CLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
    localparam logic [2:0] RD_HALF_LAST = 3'(RD_HALF_INT - 1);

    localparam int ADDR_W  = 20;
    localparam int BANK_W  = 3;
    localparam int DATA_W  = 18;
    localparam int GRP_W   = 3;
    localparam int ROW_W   = 3;
    localparam int ROW_LSB = 3;
    localparam int MEM_AW  = BANK_W + ROW_W + GRP_W;
    localparam int MEM_DEPTH = 1 << MEM_AW;

    localparam int BL_LSB = 0;
    localparam logic [1:0] BL_CODE_2   = 2'h0;
    localparam logic [1:0] BL_CODE_4   = 2'h1;
    localparam logic [1:0] BL_CODE_8   = 2'h2;
    localparam logic [1:0] BL_CODE_RSV = 2'h3;
    localparam logic [1:0] BL_CODE_RST = BL_CODE_2;
    localparam logic [3:0] BEATS_2 = 4'h2;
    localparam logic [3:0] BEATS_4 = 4'h4;
    localparam logic [3:0] BEATS_8 = 4'h8;

    // Encoded as {write enable, refresh}, both active low
    typedef enum logic [1:0] {
        CMD_MRS     = 2'h0,
        CMD_WRITE   = 2'h1,
        CMD_REFRESH = 2'h2,
        CMD_READ    = 2'h3
    } dsi_cmd_t;

    typedef enum logic [1:0] {
        RD_IDLE  = 2'h0,
        RD_WAIT  = 2'h1,
        RD_BURST = 2'h2
    } dsi_rd_state_t;

    typedef struct packed {
        logic              cmdClkP;
        logic              cmdClkN;
        logic              chipSelect_n;
        logic              writeEnable_n;
        logic              refresh_n;
        logic [BANK_W-1:0] bankSelect;
        logic [ADDR_W-1:0] addrIn;
    } dsi_cmd_bus_t;

    typedef struct packed {
        logic              wrDataClkP;
        logic              wrDataClkN;
        logic              writeMask;
        logic [DATA_W-1:0] writeDataIn;
    } dsi_wr_bus_t;
endpackage

// File: src/dsi_sync.sv
`timescale 1ns/1ps
module dsi_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1;

    // Whole group passes the same two stages so clock and data stay aligned
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// File: src/dsi_input_port.sv
`timescale 1ns/1ps
module dsi_input_port
    import dsi_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire dsi_cmd_bus_t      cmdBus,
    input  wire dsi_wr_bus_t       wrBus,
    output logic      [DATA_W-1:0] readDataOut,
    output logic                   readDataClkP,
    output logic                   readDataClkN,
    output logic                   readValidFlag
);
    function automatic logic [3:0] beatsOf(input logic [1:0] code);
        case (code)
            BL_CODE_4: beatsOf = BEATS_4;
            BL_CODE_8: beatsOf = BEATS_8;
            default:   beatsOf = BEATS_2;
        endcase
    endfunction

    // Start word of a burst: bank, row, then a column field that loses
    // one bit each time the burst doubles, so burst x span stays eight
    function automatic logic [MEM_AW-1:0] baseOf(
        input logic [BANK_W-1:0] bank,
        input logic [ADDR_W-1:0] addr,
        input logic [1:0]        code
    );
        logic [GRP_W-1:0] col;
        col = '0;
        case (code)
            BL_CODE_4: col = {addr[0], 2'h0};
            BL_CODE_8: col = 3'h0;
            default:   col = {addr[1:0], 1'h0};
        endcase
        baseOf = {bank, addr[ROW_LSB +: ROW_W], col};
    endfunction

    // Beats wrap inside the eight-word group
    function automatic logic [MEM_AW-1:0] beatAddr(
        input logic [MEM_AW-1:0] base,
        input logic [3:0]        beat
    );
        beatAddr = {base[MEM_AW-1:GRP_W],
                    base[GRP_W-1:0] + beat[GRP_W-1:0]};
    endfunction

    dsi_cmd_bus_t cmdSync;
    dsi_wr_bus_t  wrSync;

    dsi_sync #(.W($bits(dsi_cmd_bus_t))) u_cmd_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .asyncIn (cmdBus),
        .syncOut (cmdSync)
    );

    dsi_sync #(.W($bits(dsi_wr_bus_t))) u_wr_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .asyncIn (wrBus),
        .syncOut (wrSync)
    );

    // Link clock edge detection
    logic     cmdClkPrev;
    logic     wrClkPrev;
    logic     cmdRise;
    logic     wrEdge;
    logic     cmdValid;
    dsi_cmd_t cmdCode;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmdClkPrev <= 1'h0;
            wrClkPrev  <= 1'h0;
        end else begin
            cmdClkPrev <= cmdSync.cmdClkP;
            wrClkPrev  <= wrSync.wrDataClkP;
        end
    end

    assign cmdRise  = cmdSync.cmdClkP & ~cmdClkPrev;
    assign wrEdge   = wrSync.wrDataClkP ^ wrClkPrev;
    assign cmdValid = cmdRise & ~cmdSync.chipSelect_n;
    assign cmdCode  = dsi_cmd_t'({cmdSync.writeEnable_n,
                                  cmdSync.refresh_n});

    // Mode register: only the burst length field is kept
    logic [1:0] burstLen;
    logic [1:0] next_burstLen;
    logic [1:0] blField;

    assign blField = cmdSync.addrIn[BL_LSB +: 2];

    always_comb begin
        next_burstLen = burstLen;
        if (cmdValid && cmdCode == CMD_MRS && blField != BL_CODE_RSV) begin
            next_burstLen = blField;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            burstLen <= BL_CODE_RST;
        end else begin
            burstLen <= next_burstLen;
        end
    end

    // Write burst engine; refresh has no visible effect on this array
    logic              wrActive;
    logic [MEM_AW-1:0] wrBase;
    logic [3:0]        wrBeat;
    logic [3:0]        wrBeats;
    logic              next_wrActive;
    logic [MEM_AW-1:0] next_wrBase;
    logic [3:0]        next_wrBeat;
    logic [3:0]        next_wrBeats;
    logic              memWe;
    logic [MEM_AW-1:0] memWaddr;

    always_comb begin
        next_wrActive = wrActive;
        next_wrBase   = wrBase;
        next_wrBeat   = wrBeat;
        next_wrBeats  = wrBeats;
        if (cmdValid && cmdCode == CMD_WRITE) begin
            next_wrActive = 1'h1;
            next_wrBase   = baseOf(cmdSync.bankSelect, cmdSync.addrIn,
                                   burstLen);
            next_wrBeat   = 4'h0;
            next_wrBeats  = beatsOf(burstLen);
        end else if (wrActive && wrEdge) begin
            // Runs on regardless of chip select
            next_wrBeat = wrBeat + 4'h1;
            if (wrBeat + 4'h1 == wrBeats) begin
                next_wrActive = 1'h0;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrActive <= 1'h0;
            wrBase   <= '0;
            wrBeat   <= 4'h0;
            wrBeats  <= BEATS_2;
        end else begin
            wrActive <= next_wrActive;
            wrBase   <= next_wrBase;
            wrBeat   <= next_wrBeat;
            wrBeats  <= next_wrBeats;
        end
    end

    assign memWaddr = beatAddr(wrBase, wrBeat);
    // A new write command in the same cycle as an edge takes priority
    assign memWe = wrActive & wrEdge & ~wrSync.writeMask
                 & ~(cmdValid & (cmdCode == CMD_WRITE));

    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // Array is left uninitialised, as a real DRAM powers up
    always_ff @(posedge mclk) begin
        if (memWe) begin
            mem[memWaddr] <= wrSync.writeDataIn;
        end
    end

    // Read engine with free-running read clock made from mclk
    dsi_rd_state_t     rdState;
    dsi_rd_state_t     next_rdState;
    logic [2:0]        rdDiv;
    logic [2:0]        next_rdDiv;
    logic [MEM_AW-1:0] rdBase;
    logic [MEM_AW-1:0] next_rdBase;
    logic [3:0]        rdBeat;
    logic [3:0]        next_rdBeat;
    logic [3:0]        rdBeats;
    logic [3:0]        next_rdBeats;
    logic [DATA_W-1:0] next_readDataOut;
    logic              next_readDataClkP;
    logic              next_readValidFlag;
    logic              rdToggle;

    assign rdToggle = (rdDiv == RD_HALF_LAST);

    always_comb begin
        next_rdDiv         = rdToggle ? 3'h0 : rdDiv + 3'h1;
        next_readDataClkP  = rdToggle ? ~readDataClkP : readDataClkP;
        next_rdState       = rdState;
        next_rdBase        = rdBase;
        next_rdBeat        = rdBeat;
        next_rdBeats       = rdBeats;
        next_readDataOut   = readDataOut;
        next_readValidFlag = readValidFlag;
        case (rdState)
            RD_IDLE, RD_WAIT: begin
                if (cmdValid && cmdCode == CMD_READ) begin
                    next_rdState = RD_WAIT;
                    next_rdBase  = baseOf(cmdSync.bankSelect,
                                          cmdSync.addrIn, burstLen);
                    next_rdBeats = beatsOf(burstLen);
                end else if (rdState == RD_WAIT && rdToggle
                             && !readDataClkP) begin
                    // First beat goes out with a rising read clock
                    next_rdState       = RD_BURST;
                    next_readDataOut   = mem[beatAddr(rdBase, 4'h0)];
                    next_readValidFlag = 1'h1;
                    next_rdBeat        = 4'h1;
                end
            end
            RD_BURST: begin
                if (rdToggle) begin
                    if (rdBeat == rdBeats) begin
                        next_rdState       = RD_IDLE;
                        next_readValidFlag = 1'h0;
                    end else begin
                        next_readDataOut = mem[beatAddr(rdBase, rdBeat)];
                        next_rdBeat      = rdBeat + 4'h1;
                    end
                end
            end
            default: begin
                next_rdState       = RD_IDLE;
                next_readValidFlag = 1'h0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdState       <= RD_IDLE;
            rdDiv         <= 3'h0;
            rdBase        <= '0;
            rdBeat        <= 4'h0;
            rdBeats       <= BEATS_2;
            readDataOut   <= '0;
            readDataClkP  <= 1'h0;
            readDataClkN  <= 1'h1;
            readValidFlag <= 1'h0;
        end else begin
            rdState       <= next_rdState;
            rdDiv         <= next_rdDiv;
            rdBase        <= next_rdBase;
            rdBeat        <= next_rdBeat;
            rdBeats       <= next_rdBeats;
            readDataOut   <= next_readDataOut;
            readDataClkP  <= next_readDataClkP;
            readDataClkN  <= ~next_readDataClkP;
            readValidFlag <= next_readValidFlag;
        end
    end

    // Helper: length of each valid window in mclk cycles
    logic [6:0] vldCnt;
    logic [6:0] next_vldCnt;

    always_comb begin
        next_vldCnt = readValidFlag ? vldCnt + 7'h1 : 7'h0;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            vldCnt <= 7'h0;
        end else begin
            vldCnt <= next_vldCnt;
        end
    end

    a_deselect_ignored: assert property (
        @(posedge mclk) disable iff (!reset_n)
        cmdRise && cmdSync.chipSelect_n |=> $stable(burstLen)
            && !(wrActive && !$past(wrActive)))
        else $error("command taken while chip deselected");

    a_write_continues: assert property (
        @(posedge mclk) disable iff (!reset_n)
        wrActive && !wrEdge && cmdSync.chipSelect_n |=> wrActive)
        else $error("write burst stopped without a beat");

    a_mode_load: assert property (
        @(posedge mclk) disable iff (!reset_n)
        cmdValid && cmdCode == CMD_MRS && blField != BL_CODE_RSV
            |=> burstLen == $past(blField))
        else $error("mode register not loaded");

    a_bank_route: assert property (
        @(posedge mclk) disable iff (!reset_n)
        cmdValid && cmdCode == CMD_WRITE
            |=> wrBase[MEM_AW-1 -: BANK_W] == $past(cmdSync.bankSelect))
        else $error("write routed to wrong bank");

    a_column_width: assert property (
        @(posedge mclk) disable iff (!reset_n)
        cmdValid && cmdCode == CMD_WRITE && burstLen == BL_CODE_8
            |=> wrBase[GRP_W-1:0] == 3'h0 && wrBeats == BEATS_8)
        else $error("column field not cut for burst of eight");

    a_beat_stored: assert property (
        @(posedge mclk) disable iff (!reset_n)
        memWe |=> mem[$past(memWaddr)] == $past(wrSync.writeDataIn))
        else $error("unmasked beat not stored");

    a_mask_blocks: assert property (
        @(posedge mclk) disable iff (!reset_n)
        wrActive && wrEdge && wrSync.writeMask
            |=> mem[$past(memWaddr)] == $past(mem[memWaddr]))
        else $error("masked beat was stored");

    a_data_on_edge: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $changed(readDataOut) || $changed(readValidFlag)
            |-> $changed(readDataClkP) && readDataClkN != readDataClkP)
        else $error("read data moved off a read clock edge");

    a_valid_length: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $fell(readValidFlag)
            |-> $past(vldCnt) == 7'(rdBeats * RD_HALF_INT) - 7'h1)
        else $error("valid window does not match burst length");

    a_valid_start: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $rose(readValidFlag) |-> readDataClkP)
        else $error("burst did not start on rising read clock");
endmodule

// File: testbench/dsi_ctrl_model.sv
`timescale 1ns/1ps
module dsi_ctrl_model
    import dsi_pkg::*;
(
    input  wire logic   mclk,
    output dsi_cmd_bus_t cmdBus,
    output dsi_wr_bus_t  wrBus
);
    initial begin
        cmdBus = '0;
        cmdBus.cmdClkN = 1'b1;
        cmdBus.chipSelect_n = 1'b1;
        cmdBus.writeEnable_n = 1'b1;
        cmdBus.refresh_n = 1'b1;
        wrBus = '0;
        wrBus.wrDataClkN = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Fields stay put 400 ns before and 800 ns after the rising command clock
    task automatic send(input dsi_cmd_t c, input logic [BANK_W-1:0] b,
                        input logic [ADDR_W-1:0] a, input logic csN);
        @(negedge mclk);
        {cmdBus.writeEnable_n, cmdBus.refresh_n} = c;
        cmdBus.chipSelect_n = csN;
        cmdBus.bankSelect = b;
        cmdBus.addrIn = a;
        hold(4);
        cmdBus.cmdClkP = 1'b1;
        cmdBus.cmdClkN = 1'b0;
        hold(4);
        cmdBus.cmdClkP = 1'b0;
        cmdBus.cmdClkN = 1'b1;
        hold(4);
        // Released command, address and bank lines show the inverse; chip select goes high
        cmdBus.chipSelect_n = 1'b1;
        {cmdBus.writeEnable_n, cmdBus.refresh_n} = ~c;
        cmdBus.addrIn = ~a;
        cmdBus.bankSelect = ~b;
    endtask

    task automatic beat(input logic [DATA_W-1:0] d, input logic m);
        wrBus.writeDataIn = d;
        wrBus.writeMask = m;
        hold(2);
        wrBus.wrDataClkP = ~wrBus.wrDataClkP;
        wrBus.wrDataClkN = ~wrBus.wrDataClkP;
        hold(2);
    endtask

    task automatic release_wr();
        wrBus.writeDataIn = ~wrBus.writeDataIn;
        wrBus.writeMask = ~wrBus.writeMask;
    endtask
endmodule

// File: testbench/test_ddr_sio_memory_input_port.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module test_ddr_sio_memory_input_port
    import dsi_pkg::*;
();
    logic              mclk = 1'b0;
    logic              reset_n = 1'b0;
    dsi_cmd_bus_t      cmdBus;
    dsi_wr_bus_t       wrBus;
    logic [DATA_W-1:0] readDataOut;
    logic              readDataClkP;
    logic              readDataClkN;
    logic              readValidFlag;
    int                num_errors = 0;
    int                checks = 0;
    int                seed = 32'h23b3a267;
    int                bl = 2;
    int                vcnt = 0;
    int                expLen = 0;
    logic [DATA_W-1:0] exp0;
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] expQ [$];

    always #50 mclk = ~mclk;

    dsi_input_port dut_u (
        .mclk          (mclk),
        .reset_n       (reset_n),
        .cmdBus        (cmdBus),
        .wrBus         (wrBus),
        .readDataOut   (readDataOut),
        .readDataClkP  (readDataClkP),
        .readDataClkN  (readDataClkN),
        .readValidFlag (readValidFlag)
    );

    dsi_ctrl_model ctrl_u (
        .mclk   (mclk),
        .cmdBus (cmdBus),
        .wrBus  (wrBus)
    );

    task automatic finish_test();
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic int waddr(logic [2:0] b, logic [2:0] r, int c);
        return b * 64 + r * 8 + (c % 8);
    endfunction

    // Column base narrows as the burst widens
    function automatic int cbase(logic [1:0] a);
        return bl == 2 ? a * 2 : (bl == 4 ? a[0] * 4 : 0);
    endfunction

    // Beats are sampled on read clock transitions, every 4 mclk
    always @(negedge mclk) begin
        if (reset_n === 1'b1) `CHK(readDataClkN, ~readDataClkP)
        if (readValidFlag === 1'b1) begin
            if (vcnt == 0) `CHK(readDataClkP, 1'b1)
            if (vcnt % 4 == 0) begin
                exp0 = expQ.pop_front();
                `CHK(readDataOut, exp0)
            end
            vcnt++;
        end else if (vcnt != 0) begin
            `CHK(vcnt, expLen * 4)
            vcnt = 0;
        end
    end

    task automatic mode(input logic [1:0] code);
        ctrl_u.send(CMD_MRS, 3'($random(seed)),
                    {18'($random(seed)), code}, 1'b0);
        if (code != BL_CODE_RSV)
            bl = code == BL_CODE_8 ? 8 : (code == BL_CODE_4 ? 4 : 2);
    endtask

    task automatic do_write(input logic [2:0] b, r, input logic [1:0] a,
                            input logic [7:0] m, input logic csN);
        logic [ADDR_W-1:0] ad;
        logic [DATA_W-1:0] d;
        int                c;
        ad = $random(seed);
        ad[5:3] = r;
        ad[1:0] = a;
        c = cbase(a);
        ctrl_u.send(CMD_WRITE, b, ad, csN);
        for (int k = 0; k < bl; k++) begin
            d = $random(seed);
            ctrl_u.beat(d, m[k]);
            if (!m[k] && !csN) mem[waddr(b, r, c + k)] = d;
        end
        ctrl_u.release_wr();
    endtask

    task automatic start_read(input logic [2:0] b, r, input logic [1:0] a);
        logic [ADDR_W-1:0] ad;
        int                c;
        ad = $random(seed);
        ad[5:3] = r;
        ad[1:0] = a;
        c = cbase(a);
        expLen = bl;
        for (int k = 0; k < bl; k++)
            expQ.push_back(mem[waddr(b, r, c + k)]);
        ctrl_u.send(CMD_READ, b, ad, 1'b0);
    endtask

    task automatic wait_read();
        int n;
        n = 0;
        while ((expQ.size() != 0 || vcnt != 0) && n < 100) begin
            @(negedge mclk);
            n++;
        end
        if (n == 100) begin
            num_errors++;
            $display("unexpected at %0t: read burst missing", $time);
            finish_test();
        end
    endtask

    initial begin
        logic [2:0] bks [3];
        logic [2:0] rws [3];
        repeat (10) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        mode(BL_CODE_8);
        for (int i = 0; i < 3; i++) begin
            bks[i] = 3'(i * 3 + ($random(seed) & 1));
            rws[i] = $random(seed);
            do_write(bks[i], rws[i], 2'($random(seed)), 8'h00, 1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            start_read(bks[i], rws[i], 2'($random(seed)));
            wait_read();
        end
        mode(BL_CODE_4);
        do_write(bks[2], rws[2], 2'h1, 8'h02, 1'b0);
        start_read(bks[2], rws[2], 2'h1);
        wait_read();
        mode(BL_CODE_2);
        do_write(bks[2], rws[2], 2'h3, 8'h01, 1'b0);
        start_read(bks[2], rws[2], 2'h3);
        wait_read();
        // Reserved code keeps the burst, refresh changes no data
        mode(BL_CODE_RSV);
        ctrl_u.send(CMD_REFRESH, bks[2], 20'($random(seed)), 1'b0);
        do_write(bks[2], rws[2], 2'h2, 8'h00, 1'b1);
        start_read(bks[2], rws[2], 2'h2);
        wait_read();
        mode(BL_CODE_8);
        start_read(bks[1], rws[1], 2'h0);
        ctrl_u.send(CMD_MRS, bks[1], {18'h0, BL_CODE_2}, 1'b1);
        wait_read();
        start_read(bks[0], rws[0], 2'h0);
        wait_read();
        finish_test();
    end
endmodule
